// file: rtl/xcvr_cfg.svh
// timing constants and idle levels for the transceiver mode controller
`ifndef XCVR_CFG_SVH
`define XCVR_CFG_SVH

// reference clock period in ns
`define CLK_NS       50
// mode-change transition time in ns (least wait)
`define MOCH_NS      10000
// start-up time after supply recovery in ns (least wait)
`define STARTUP_NS   250000
// transmit pin level held while the device is off or booting
`define TXD_IDLE     1'h1
// receive value reported while the receiver is not trusted
`define RX_IDLE      1'h1

`endif

// file: rtl/xcvr_pkg.sv
// types shared by the transceiver mode controller
package xcvr_pkg;

  // operating mode requested or applied
  typedef enum logic [1:0]
  {
    MODE_OFF    = 2'h0,
    MODE_NORMAL = 2'h1,
    MODE_SILENT = 2'h2
  } mode_e;

  // controller sequence state, gray coded along off-boot-switch-active
  typedef enum logic [1:0]
  {
    ST_OFF    = 2'h0,
    ST_BOOT   = 2'h1,
    ST_SWITCH = 2'h3,
    ST_ACTIVE = 2'h2
  } state_e;

  // levels driven onto the transceiver control pins
  typedef struct packed
  {
    logic txd;   // transmit data pin, low = dominant
    logic sel;   // quiet-select pin (active high) or active-low quiet pin
    logic off;   // power-down pin, used only in the power-down variant
  } pin_out_s;

endpackage

// file: rtl/xcvr_mode_ctrl.sv
// host-side controller that drives transceiver mode pins and transmit data
`timescale 1ns/100ps
`default_nettype none
`include "xcvr_cfg.svh"

// What this block does
// RL1 - single-pin variant: quiet pin low gives Normal
// RL2 - single-pin variant: quiet pin high gives Silent
// RL3 - power-down variant: both pins low gives Silent
// RL4 - power-down variant: quiet high, power-down low: Normal
// RL5 - power-down pin high forces Off
// RL6 - Off mode: bus and receive output float
// RL7 - supply undervoltage forces Off from any mode
// RL8 - Off is the state at power-up
// RL9 - after supply recovery wait start-up, then mode
// RL10 - mode changes complete within transition time
// RL11 - transmit high seen before first dominant
// RL12 - Normal: transmit low dominant, high recessive
// RL13 - receive low dominant, high recessive when active
// RL14 - Silent: transmitter disabled, receiver still active
// RL15 - supply flags override the mode pins
module xcvr_mode_ctrl
  import xcvr_pkg::*;
#(
  parameter bit PD_VARIANT  = 1'b0,   // 1: power-down pin variant
  parameter int STARTUP_CYC = (`STARTUP_NS + `CLK_NS - 1) / `CLK_NS
)
(
  // clock and reset
  input  wire logic             REF_CLK,
  input  wire logic             RSTN,
  // user side
  input  wire xcvr_pkg::mode_e  MODE_REQ,
  input  wire logic             TX_DATA,
  output var  logic             RX_DATA,
  output var  xcvr_pkg::mode_e  MODE_NOW,
  output var  logic             READY,
  // transceiver side
  input  wire logic             SUPPLY_OK,
  input  wire logic             RXD_PIN,
  output var  xcvr_pkg::pin_out_s XCVR_PINS
);
  import xcvr_pkg::*;

  localparam int MOCH_CYC = (`MOCH_NS + `CLK_NS - 1) / `CLK_NS;
  localparam logic [15:0] MOCH_LOAD  = 16'(MOCH_CYC - 1);
  localparam logic [15:0] START_LOAD = 16'(STARTUP_CYC - 1);

  // synchronisers for asynchronous pins
  logic     sup_ff1_q;    // supply flag, first stage
  logic     sup_ff2_q;    // supply flag, usable
  logic     rxd_ff1_q;    // receive pin, first stage
  logic     rxd_ff2_q;    // receive pin, usable
  // sequence state
  state_e   state_q, state_d;
  mode_e    cur_q, cur_d;          // mode applied to the pins
  logic [15:0] tmr_q, tmr_d;       // wait counter
  logic     seen_q, seen_d;        // transmit high seen in Normal
  pin_out_s pins_q, pins_d;        // registered pin levels
  logic     rx_q, rx_d;            // registered receive data
  logic     rdy_q, rdy_d;          // mode settled

  // two-stage synchronisers
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sup_ff1_q <= 1'h0;
      sup_ff2_q <= 1'h0;
      rxd_ff1_q <= 1'h1;
      rxd_ff2_q <= 1'h1;
    end
    else
    begin
      sup_ff1_q <= SUPPLY_OK;
      sup_ff2_q <= sup_ff1_q;
      rxd_ff1_q <= RXD_PIN;
      rxd_ff2_q <= rxd_ff1_q;
    end
  end

  // pin levels that select a given mode
  function automatic pin_out_s mode_pins(input mode_e m);
    pin_out_s p;
    p.txd = `TXD_IDLE;
    p.off = 1'h0;
    case (m)
      MODE_NORMAL: p.sel = PD_VARIANT ? 1'h1 : 1'h0;   // see RL1 see RL4
      MODE_SILENT: p.sel = PD_VARIANT ? 1'h0 : 1'h1;   // see RL2 see RL3
      default:
      begin
        // off: power-down pin high; single-pin variant parks in silent
        p.sel = PD_VARIANT ? 1'h0 : 1'h1;
        p.off = PD_VARIANT;                            // see RL5
      end
    endcase
    return p;
  endfunction

  // next-state logic for sequence, pins and receive data
  always_comb
  begin
    state_d = state_q;
    cur_d   = cur_q;
    tmr_d   = tmr_q;
    case (state_q)
      ST_OFF:
      begin
        // power-up and undervoltage both land here
        if (sup_ff2_q)
        begin
          state_d = ST_BOOT;
          tmr_d   = START_LOAD;
        end
      end
      ST_BOOT:
      begin
        // device initialises; selected mode applies after start-up
        if (tmr_q == 16'h0)
        begin
          state_d = ST_SWITCH;                         // see RL9
          cur_d   = MODE_REQ;
          tmr_d   = MOCH_LOAD;
        end
        else
          tmr_d = tmr_q - 16'h1;
      end
      ST_SWITCH:
      begin
        // pins changed; allow transition time before trusting mode
        if (tmr_q == 16'h0)
          state_d = ST_ACTIVE;                         // see RL10
        else
          tmr_d = tmr_q - 16'h1;
      end
      ST_ACTIVE:
      begin
        // a new request restarts the transition wait
        if (MODE_REQ != cur_q)
        begin
          state_d = ST_SWITCH;
          cur_d   = MODE_REQ;
          tmr_d   = MOCH_LOAD;
        end
      end
      default:
      begin
        state_d = ST_OFF;
        tmr_d   = 16'h0;
      end
    endcase
    // supply loss overrides everything else
    if (!sup_ff2_q)
    begin
      state_d = ST_OFF;                                // see RL7 see RL15
      cur_d   = MODE_OFF;
      tmr_d   = 16'h0;
    end
    // transmit-high gate, cleared whenever Normal is not active
    seen_d = (state_q == ST_ACTIVE) && (cur_q == MODE_NORMAL) &&
             (seen_q || pins_q.txd);                   // see RL11
    // pin levels follow the applied mode
    pins_d = mode_pins(cur_d);
    if ((state_d == ST_OFF) || (state_d == ST_BOOT))
      pins_d = mode_pins(MODE_OFF);
    if ((state_q == ST_ACTIVE) && (cur_q == MODE_NORMAL) && seen_q &&
        (state_d == ST_ACTIVE))
      pins_d.txd = TX_DATA;                            // see RL12
    // receiver floats in off, so report recessive unless active in normal or silent
    if ((state_q == ST_ACTIVE) && (cur_q != MODE_OFF))
      rx_d = rxd_ff2_q;                                // see RL13 see RL14
    else
      rx_d = `RX_IDLE;                                 // see RL6
    rdy_d = (state_d == ST_ACTIVE);
  end

  // state registers; off at reset
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_q <= ST_OFF;                               // see RL8
      cur_q   <= MODE_OFF;
      tmr_q   <= 16'h0;
      seen_q  <= 1'h0;
      pins_q  <= '{txd: 1'h1, sel: 1'h1, off: 1'h0};
      rx_q    <= 1'h1;
      rdy_q   <= 1'h0;
    end
    else
    begin
      state_q <= state_d;
      cur_q   <= cur_d;
      tmr_q   <= tmr_d;
      seen_q  <= seen_d;
      pins_q  <= pins_d;
      rx_q    <= rx_d;
      rdy_q   <= rdy_d;
    end
  end

  // outputs straight from flip-flops
  assign XCVR_PINS = pins_q;
  assign RX_DATA   = rx_q;
  assign MODE_NOW  = cur_q;
  assign READY     = rdy_q;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  a_normal_pin: assert property (  // see RL1
    (!PD_VARIANT && cur_q == MODE_NORMAL && state_q != ST_OFF) |-> !pins_q.sel)
    else $error("quiet pin not low in normal");
  a_silent_pin: assert property (  // see RL2
    (!PD_VARIANT && cur_q == MODE_SILENT && state_q == ST_ACTIVE) |-> pins_q.sel)
    else $error("quiet pin not high in silent");
  a_pd_silent: assert property (  // see RL3
    (PD_VARIANT && cur_q == MODE_SILENT && state_q == ST_ACTIVE)
      |-> (!pins_q.sel && !pins_q.off))
    else $error("pd variant silent pins wrong");
  a_pd_normal: assert property (  // see RL4
    (PD_VARIANT && cur_q == MODE_NORMAL && state_q == ST_ACTIVE)
      |-> (pins_q.sel && !pins_q.off))
    else $error("pd variant normal pins wrong");
  a_off_pin: assert property (  // see RL5
    (PD_VARIANT && state_q == ST_BOOT) |-> pins_q.off)
    else $error("power-down pin not high while booting");
  a_off_rx: assert property (  // see RL6
    (state_q == ST_OFF) |=> rx_q)
    else $error("receive data not idle in off");
  a_uv_off: assert property (  // see RL7
    !sup_ff2_q |=> (state_q == ST_OFF && !rdy_q))
    else $error("supply loss did not force off");
  a_boot_wait: assert property (  // see RL9
    (state_q == ST_OFF && sup_ff2_q) |=> (state_q == ST_BOOT)[*8])
    else $error("start-up wait cut short");
  a_moch_done: assert property (  // see RL10
    (state_q == ST_SWITCH && $changed(cur_q) && sup_ff2_q)
      |-> ##[1:250] (state_q == ST_ACTIVE || state_q == ST_OFF || $changed(cur_q)))
    else $error("mode change not completed in time");
  a_high_first: assert property (  // see RL11
    ($rose(state_q == ST_ACTIVE) && cur_q == MODE_NORMAL) |-> pins_q.txd)
    else $error("dominant before transmit high");
  a_tx_silent: assert property (  // see RL14
    (cur_q != MODE_NORMAL) |-> pins_q.txd)
    else $error("transmit driven outside normal");
  a_tx_follow: assert property (  // see RL12
    (state_q == ST_ACTIVE && cur_q == MODE_NORMAL && seen_q && sup_ff2_q &&
     MODE_REQ == cur_q) |=> (pins_q.txd == $past(TX_DATA)))
    else $error("transmit pin does not follow data");
  a_rx_follow: assert property (  // see RL13
    (state_q == ST_ACTIVE && cur_q != MODE_OFF) |=> (rx_q == $past(rxd_ff2_q)))
    else $error("receive data does not follow bus");

  c_normal: cover property (state_q == ST_ACTIVE && cur_q == MODE_NORMAL && !pins_q.txd);
  c_silent: cover property (state_q == ST_ACTIVE && cur_q == MODE_SILENT);
  c_uv_drop: cover property (state_q == ST_ACTIVE ##1 state_q == ST_OFF);
  c_switch: cover property (state_q == ST_ACTIVE ##1 state_q == ST_SWITCH);

endmodule
`default_nettype wire

// file: verif/xcvr_dev_model.sv
// transceiver model: mode pins, bus driver and receive pin
`timescale 1ns/100ps
`default_nettype none
module xcvr_dev_model
#(
  parameter bit PD = 1'b0  // power-down pin variant
)
(
  // clock and supply
  input  wire logic               clk,
  input  wire logic               sup_ok,
  // controller pins and the rest of the bus
  input  wire xcvr_pkg::pin_out_s pins,
  input  wire logic               other_dom,
  // receive pin and bus state
  output var  logic               rxd,
  output var  logic               bus_dom
);
  import xcvr_pkg::*;
  mode_e mode;           // applied mode
  logic  seen_q;         // recessive input seen in normal
  logic  tog_q = 1'b0;   // pattern on the floating pin
  // supply flag first, then the pins
  always_comb
  begin
    if (!sup_ok)
      mode = MODE_OFF;
    else if (PD)
      mode = pins.off ? MODE_OFF : (pins.sel ? MODE_NORMAL : MODE_SILENT);
    else
      mode = pins.sel ? MODE_SILENT : MODE_NORMAL;
  end
  // arming of the driver and the float pattern
  always_ff @(posedge clk)
  begin
    seen_q <= (mode == MODE_NORMAL) && (seen_q || pins.txd);
    tog_q  <= ~tog_q;
  end
  // only normal mode drives; silent only listens
  assign bus_dom = other_dom || (mode == MODE_NORMAL && seen_q && !pins.txd);
  // receive pin floats when off
  assign rxd = (mode == MODE_OFF) ? tog_q : !bus_dom;
endmodule
`default_nettype wire

// file: verif/tb.sv
// testbench for the transceiver mode controller
`timescale 1ns/100ps
`default_nettype none
module tb;
  import xcvr_pkg::*;
  logic     ref_clk   = 1'b0;
  logic     rstn      = 1'b0;
  logic     tx_data   = 1'b0;  // low from the start: the gate admits dominant once the idle-high pin level is seen
  logic     supply_ok = 1'b0;
  logic     other_dom = 1'b0;
  mode_e    mode_req  = MODE_NORMAL;
  mode_e    mode_now;
  logic     rx_data, ready, rxd, bus_dom;
  pin_out_s pins, pins_pd;
  int       checks    = 0;
  int       bad_count = 0;
  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;
  xcvr_mode_ctrl #(.PD_VARIANT(1'b0), .STARTUP_CYC(10)) uut (.REF_CLK(ref_clk), .RSTN(rstn),
    .MODE_REQ(mode_req), .TX_DATA(tx_data), .RX_DATA(rx_data), .MODE_NOW(mode_now),
    .READY(ready), .SUPPLY_OK(supply_ok), .RXD_PIN(rxd), .XCVR_PINS(pins));
  xcvr_mode_ctrl #(.PD_VARIANT(1'b1), .STARTUP_CYC(10)) uut_pd (.REF_CLK(ref_clk), .RSTN(rstn),
    .MODE_REQ(mode_req), .TX_DATA(tx_data), .RX_DATA(), .MODE_NOW(), .READY(),
    .SUPPLY_OK(supply_ok), .RXD_PIN(rxd), .XCVR_PINS(pins_pd));
  xcvr_dev_model #(.PD(1'b0)) dev (.clk(ref_clk), .sup_ok(supply_ok), .pins(pins),
    .other_dom(other_dom), .rxd(rxd), .bus_dom(bus_dom));
  // one comparison
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // counts and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // bounded wait for settle, count must fall in range
  task automatic wait_ready(input int lo, input int hi);
    int n;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end while (ready !== 1'b1 && n <= hi);
    chk("settle count", 4'h1, {3'h0, n >= lo && n <= hi});
    if (n > hi)
      summarize();
  endtask
  // power-up and reset levels
  task automatic t_reset();
    chk("reset pins", 4'h6, {1'b0, pins});
    chk("reset rx ready mode", 4'h8, {rx_data, ready, mode_now});
  endtask
  // supply up, start-up then normal, no dominant before a recessive
  task automatic t_bringup();
    supply_ok = 1'b1;
    cyc(5);
    chk("pd off while booting", 4'h1, {3'h0, pins_pd.off});
    wait_ready(206, 210);
    chk("normal pins", 4'h4, {1'b0, pins});
    chk("pd normal pins", 4'h6, {1'b0, pins_pd});
    chk("no dominant yet", 4'h4, {bus_dom, pins});
    cyc(3);
    chk("dominant after high", 4'h8, {bus_dom, pins});
  endtask
  // transmit path and receive path
  task automatic t_tx();
    tx_data = 1'b1;
    cyc(3);
    tx_data = 1'b0;
    cyc(2);
    chk("dominant", 4'h8, {bus_dom, pins});
    cyc(4);
    chk("rx dominant", 4'h0, {3'h0, rx_data});
    tx_data = 1'b1;
    cyc(6);
    chk("recessive", 4'h1, {1'b0, bus_dom, 1'b0, rx_data});
  endtask
  // silent: transmit low ignored, receiver alive
  task automatic t_silent();
    mode_req = MODE_SILENT;
    tx_data  = 1'b0;
    wait_ready(200, 205);
    chk("silent pins", 4'h6, {bus_dom, pins});
    chk("pd silent pins", 4'h4, {1'b0, pins_pd});
    chk("silent mode", {2'h0, MODE_SILENT}, {2'h0, mode_now});
    other_dom = 1'b1;
    cyc(5);
    chk("silent rx", 4'h0, {3'h0, rx_data});
    other_dom = 1'b0;
  endtask
  // off request and supply loss
  task automatic t_off();
    mode_req = MODE_OFF;
    cyc(4);
    chk("pd off pin", 4'h1, {3'h0, pins_pd.off});
    chk("single quiet pin", 4'h1, {3'h0, pins.sel});
    wait_ready(195, 200);
    chk("off settled", 4'hC, {rx_data, ready, mode_now});
    supply_ok = 1'b0;
    cyc(4);
    chk("supply loss", 4'h8, {rx_data, ready, mode_now});
  endtask
  // main sequence
  initial
  begin
    cyc(2);
    t_reset();
    rstn = 1'b1;
    cyc(1);
    t_bringup();
    t_tx();
    t_silent();
    t_off();
    summarize();
  end
endmodule
`default_nettype wire
